// file: shared/scl_pkg.sv
`default_nettype none

package scl_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;

   // Least time in ns to whole cycles, rounded up, at least one.
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Longest time in ns to whole cycles, rounded down, at least one.
   function automatic int cyc_dn(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int LP_STATE_MIN_NS = 50;
   localparam int CLK_PREPARE_NS = 38;
   localparam int CLK_ZERO_NS = 262;
   localparam int CLK_TRAIL_NS = 60;
   localparam int CLK_POST_NS = 60;
   localparam int HS_EXIT_NS = 100;
   localparam int WAKEUP_NS = 1000000;
   localparam int CLK_MISS_NS = 60;
   localparam int CLK_TERM_EN_NS = 38;
   localparam int CLK_SETTLE_NS = 95;

   localparam int LP_STATE_MIN_CYC = cyc_up(LP_STATE_MIN_NS);
   localparam int CLK_PREPARE_CYC = cyc_up(CLK_PREPARE_NS);
   localparam int CLK_ZERO_CYC = cyc_up(CLK_ZERO_NS);
   localparam int CLK_TRAIL_CYC = cyc_up(CLK_TRAIL_NS);
   localparam int CLK_POST_CYC = cyc_up(CLK_POST_NS);
   localparam int HS_EXIT_CYC = cyc_up(HS_EXIT_NS);
   localparam int WAKEUP_CYC = cyc_up(WAKEUP_NS);
   localparam int CLK_MISS_CYC = cyc_dn(CLK_MISS_NS);
   localparam int CLK_TERM_EN_CYC = cyc_dn(CLK_TERM_EN_NS);
   localparam int CLK_SETTLE_CYC = cyc_up(CLK_SETTLE_NS);

   // Clock phases (unit intervals) before data lanes may start, and after.
   localparam int CLK_PRE_PHASES = 8;
   localparam int CLK_POST_PHASES = 52;
   localparam int HS_HALF_CYC = 1;
   localparam int TMR_W = 16;

   // ----------------------------------------------------------------
   // Low-power line states, bit 1 is the positive line
   // ----------------------------------------------------------------
   localparam logic [1:0] LINE_LP00 = 2'h0;
   localparam logic [1:0] LINE_LP01 = 2'h1;
   localparam logic [1:0] LINE_LP10 = 2'h2;
   localparam logic [1:0] LINE_LP11 = 2'h3;

   localparam logic [1:0] LINE_RST = LINE_LP11;

endpackage

`default_nettype wire

// file: rtl/scl_clock_lane.sv
// How it works
// RULE_01 - Clock runs post interval, ends on zero.
// RULE_02 - After trail, slow driver drives stop.
// RULE_03 - Receiver drops fast receiver on clock miss.
// RULE_04 - Stop lines remove termination, receiver stops.
// RULE_05 - Fast request drives LP-01 minimum time.
// RULE_06 - Then LP-00 for the prepare time.
// RULE_07 - Drivers swap together, zero for lead time.
// RULE_08 - Toggle one and zero until stop request.
// RULE_09 - Clock runs pre interval before data starts.
// RULE_10 - Leave toggling after one phase, then trail.
// RULE_11 - Receiver follows LP-01 then LP-00 to prepare.
// RULE_12 - Termination on after termination-enable time.
// RULE_13 - Ignore clock until settle time ends.
// RULE_14 - Sleep entry drives LP-10 then LP-00.
// RULE_15 - Bad line after sleep request aborts entry.
// RULE_16 - Flag deep sleep while lines hold LP-00.
// RULE_17 - Sleep exit drives LP-10 then stop.
// RULE_18 - Receiver tracks sleep request, sleep, exit, stop.
// RULE_19 - Sleep supported without escape command handling.
// RULE_20 - Protocol stops clock only with data idle.
// RULE_21 - Every burst starts and ends on zero.
// RULE_22 - Intervals timed by counters loaded on entry.
`timescale 1ns/100ps
`default_nettype none

module scl_clock_lane #(
   parameter int WAKEUP_CYC = scl_pkg::WAKEUP_CYC,
   parameter int HS_HALF_CYC = scl_pkg::HS_HALF_CYC,
   parameter int CLK_PRE_PHASES = scl_pkg::CLK_PRE_PHASES,
   parameter int CLK_POST_PHASES = scl_pkg::CLK_POST_PHASES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Transmit protocol interface
   input wire logic tx_fast_req_i,
   input wire logic tx_sleep_req_i,
   output logic tx_clk_ready_o,
   output logic tx_stop_o,
   output logic tx_sleep_o,
   // Transmit pins
   output logic tx_fast_en_o,
   output logic tx_fast_lvl_o,
   output logic tx_slow_en_o,
   output logic tx_slow_p_o,
   output logic tx_slow_n_o,
   // Receive pins
   input wire logic rx_slow_p_i,
   input wire logic rx_slow_n_i,
   input wire logic rx_fast_lvl_i,
   // Receive control and protocol interface
   output logic rx_term_en_o,
   output logic rx_fast_en_o,
   output logic rx_clk_valid_o,
   output logic rx_clk_o,
   output logic rx_stop_o,
   output logic rx_deep_sleep_o
);

   localparam int TW = scl_pkg::TMR_W;
   localparam int POST_CYC = scl_pkg::CLK_POST_CYC + CLK_POST_PHASES * HS_HALF_CYC;

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (WAKEUP_CYC < 1 || WAKEUP_CYC >= (1 << TW) || HS_HALF_CYC < 1 || HS_HALF_CYC > 255
       || CLK_PRE_PHASES < 1 || CLK_PRE_PHASES > 255 || POST_CYC >= (1 << TW))
   begin : g_bad_param
      $error("scl_clock_lane: parameter out of range");
   end

   // ----------------------------------------------------------------
   // Transmit state machine
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      TX_STOP,
      TX_FAST_REQUEST,
      TX_BRIDGE,
      TX_LEAD_ZERO,
      TX_HS0,
      TX_HS1,
      TX_TRAILING,
      TX_EXIT,
      TX_SLEEP_REQUEST,
      TX_SLEEP,
      TX_SLEEP_EXIT
   } scl_tx_st_t;

   scl_tx_st_t tx_st_q;
   scl_tx_st_t tx_st_d;
   logic [TW-1:0] tx_tmr_q;
   logic [7:0] tx_ph_q;
   logic [TW-1:0] tx_post_q;
   logic [4:0] tx_pins_q;

   // Interval length of each timed transmit state.
   function automatic logic [TW-1:0] tx_len(input scl_tx_st_t st);
      case (st)
         TX_FAST_REQUEST: tx_len = TW'(scl_pkg::LP_STATE_MIN_CYC);
         TX_BRIDGE: tx_len = TW'(scl_pkg::CLK_PREPARE_CYC);
         TX_LEAD_ZERO: tx_len = TW'(scl_pkg::CLK_ZERO_CYC);
         TX_HS0: tx_len = TW'(HS_HALF_CYC);
         TX_HS1: tx_len = TW'(HS_HALF_CYC);
         TX_TRAILING: tx_len = TW'(scl_pkg::CLK_TRAIL_CYC);
         TX_EXIT: tx_len = TW'(scl_pkg::HS_EXIT_CYC);
         TX_SLEEP_REQUEST: tx_len = TW'(scl_pkg::LP_STATE_MIN_CYC);
         TX_SLEEP_EXIT: tx_len = TW'(WAKEUP_CYC);
         default: tx_len = TW'(1);
      endcase
   endfunction

   // Pin pattern {fast_en, fast_lvl, slow_en, slow_p, slow_n} of a state.
   function automatic logic [4:0] tx_line(input scl_tx_st_t st);
      case (st)
         TX_FAST_REQUEST: tx_line = {2'h0, 1'b1, scl_pkg::LINE_LP01};
         TX_BRIDGE: tx_line = {2'h0, 1'b1, scl_pkg::LINE_LP00};
         TX_LEAD_ZERO: tx_line = 5'h10;
         TX_HS0: tx_line = 5'h10;
         TX_HS1: tx_line = 5'h18;
         TX_TRAILING: tx_line = 5'h10;
         TX_SLEEP_REQUEST: tx_line = {2'h0, 1'b1, scl_pkg::LINE_LP10};
         TX_SLEEP: tx_line = {2'h0, 1'b1, scl_pkg::LINE_LP00};
         TX_SLEEP_EXIT: tx_line = {2'h0, 1'b1, scl_pkg::LINE_LP10};
         default: tx_line = {2'h0, 1'b1, scl_pkg::LINE_LP11};
      endcase
   endfunction

   wire tx_tmr_done = (tx_tmr_q == TW'(1));
   wire tx_toggling = (tx_st_q == TX_HS0) || (tx_st_q == TX_HS1);
   wire tx_pre_done = (tx_ph_q >= 8'(CLK_PRE_PHASES));
   wire tx_post_done = (tx_post_q >= TW'(POST_CYC));
   wire tx_lp_req = !tx_fast_req_i && tx_post_done && tx_pre_done;

   always_comb
   begin
      tx_st_d = tx_st_q;
      case (tx_st_q)
         TX_STOP:
         begin
            if (tx_fast_req_i)
               tx_st_d = TX_FAST_REQUEST; // RULE_05
            else if (tx_sleep_req_i)
               tx_st_d = TX_SLEEP_REQUEST; // RULE_14
         end
         TX_FAST_REQUEST: if (tx_tmr_done) tx_st_d = TX_BRIDGE; // RULE_06
         TX_BRIDGE: if (tx_tmr_done) tx_st_d = TX_LEAD_ZERO; // RULE_07
         TX_LEAD_ZERO: if (tx_tmr_done) tx_st_d = TX_HS1; // RULE_08
         TX_HS0: if (tx_tmr_done) tx_st_d = TX_HS1; // RULE_08
         TX_HS1:
         begin
            if (tx_tmr_done && tx_lp_req)
               tx_st_d = TX_TRAILING; // RULE_10
            else if (tx_tmr_done)
               tx_st_d = TX_HS0; // RULE_08
         end
         TX_TRAILING: if (tx_tmr_done) tx_st_d = TX_EXIT; // RULE_02
         TX_EXIT: if (tx_tmr_done) tx_st_d = TX_STOP; // RULE_02
         TX_SLEEP_REQUEST: if (tx_tmr_done) tx_st_d = TX_SLEEP; // RULE_14
         TX_SLEEP: if (!tx_sleep_req_i) tx_st_d = TX_SLEEP_EXIT; // RULE_17
         TX_SLEEP_EXIT: if (tx_tmr_done) tx_st_d = TX_STOP; // RULE_17
         default:
            tx_st_d = TX_STOP;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_st_q <= TX_STOP;
         tx_tmr_q <= TW'(1);
         tx_pins_q <= {2'h0, 1'b1, scl_pkg::LINE_RST};
      end
      else
      begin
         tx_st_q <= tx_st_d;
         tx_pins_q <= tx_line(tx_st_d); // RULE_07 RULE_21
         if (tx_st_d != tx_st_q)
            tx_tmr_q <= tx_len(tx_st_d); // RULE_22
         else if (tx_tmr_q != TW'(1))
            tx_tmr_q <= tx_tmr_q - TW'(1);
      end
   end

   // Phases sent since the clock started, and time since data went idle.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_ph_q <= 8'h0;
         tx_post_q <= TW'(0);
      end
      else
      begin
         if (!tx_toggling)
            tx_ph_q <= 8'h0;
         else if (tx_tmr_done && !tx_pre_done)
            tx_ph_q <= tx_ph_q + 8'h1; // RULE_09
         if (!tx_toggling || tx_fast_req_i)
            tx_post_q <= TW'(0);
         else if (!tx_post_done)
            tx_post_q <= tx_post_q + TW'(1); // RULE_01
      end
   end

   assign tx_fast_en_o = tx_pins_q[4];
   assign tx_fast_lvl_o = tx_pins_q[3];
   assign tx_slow_en_o = tx_pins_q[2];
   assign tx_slow_p_o = tx_pins_q[1];
   assign tx_slow_n_o = tx_pins_q[0];
   // Data lanes may start once the clock has run its pre interval.
   assign tx_clk_ready_o = tx_toggling && tx_pre_done; // RULE_09 RULE_20
   assign tx_stop_o = (tx_st_q == TX_STOP);
   assign tx_sleep_o = (tx_st_q == TX_SLEEP); // RULE_19

   // ----------------------------------------------------------------
   // Receive pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] rx_sync_a_q;
   logic [2:0] rx_sync_b_q;
   logic [2:0] rx_sync_c_q;
   logic [1:0] rx_line_q;
   logic rx_hs_q;
   logic rx_hs_prev_q;

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rx_sync_a_q <= 3'h7;
         rx_sync_b_q <= 3'h7;
         rx_sync_c_q <= 3'h0;
         rx_line_q <= scl_pkg::LINE_RST;
         rx_hs_q <= 1'b0;
         rx_hs_prev_q <= 1'b0;
      end
      else
      begin
         rx_sync_a_q <= {rx_sync_a_q[1:0], rx_slow_p_i};
         rx_sync_b_q <= {rx_sync_b_q[1:0], rx_slow_n_i};
         rx_sync_c_q <= {rx_sync_c_q[1:0], rx_fast_lvl_i};
         if (rx_sync_a_q[1] == rx_sync_a_q[2])
            rx_line_q[1] <= rx_sync_a_q[2];
         if (rx_sync_b_q[1] == rx_sync_b_q[2])
            rx_line_q[0] <= rx_sync_b_q[2];
         if (rx_sync_c_q[1] == rx_sync_c_q[2])
            rx_hs_q <= rx_sync_c_q[2];
         rx_hs_prev_q <= rx_hs_q;
      end
   end

   // ----------------------------------------------------------------
   // Receive state machine
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      RX_STOP,
      RX_FAST_REQUEST,
      RX_PREPARE,
      RX_TERMINATION,
      RX_CLOCK_RECEIVE,
      RX_END,
      RX_SLEEP_REQUEST,
      RX_SLEEP,
      RX_SLEEP_EXIT,
      RX_WAIT
   } scl_rx_st_t;

   scl_rx_st_t rx_st_q;
   scl_rx_st_t rx_st_d;
   logic [TW-1:0] rx_tmr_q;
   logic [5:0] rx_out_q;

   // Interval length of each timed receive state.
   function automatic logic [TW-1:0] rx_len(input scl_rx_st_t st);
      case (st)
         RX_PREPARE: rx_len = TW'(scl_pkg::CLK_TERM_EN_CYC);
         RX_TERMINATION: rx_len = TW'(scl_pkg::CLK_SETTLE_CYC);
         RX_CLOCK_RECEIVE: rx_len = TW'(scl_pkg::CLK_MISS_CYC);
         default: rx_len = TW'(1);
      endcase
   endfunction

   wire rx_tmr_done = (rx_tmr_q == TW'(1));
   wire rx_edge = rx_hs_q ^ rx_hs_prev_q;
   wire rx_is11 = (rx_line_q == scl_pkg::LINE_LP11);
   wire rx_is10 = (rx_line_q == scl_pkg::LINE_LP10);
   wire rx_is01 = (rx_line_q == scl_pkg::LINE_LP01);
   wire rx_is00 = (rx_line_q == scl_pkg::LINE_LP00);

   always_comb
   begin
      rx_st_d = rx_st_q;
      case (rx_st_q)
         RX_STOP:
         begin
            if (rx_is01)
               rx_st_d = RX_FAST_REQUEST; // RULE_11
            else if (rx_is10)
               rx_st_d = RX_SLEEP_REQUEST; // RULE_18
         end
         RX_FAST_REQUEST:
         begin
            if (rx_is00)
               rx_st_d = RX_PREPARE; // RULE_11
            else if (rx_is11)
               rx_st_d = RX_STOP;
         end
         RX_PREPARE: if (rx_tmr_done) rx_st_d = RX_TERMINATION; // RULE_12
         RX_TERMINATION: if (rx_tmr_done) rx_st_d = RX_CLOCK_RECEIVE; // RULE_13
         RX_CLOCK_RECEIVE: if (rx_tmr_done && !rx_edge) rx_st_d = RX_END; // RULE_03
         RX_END: if (rx_is11) rx_st_d = RX_STOP; // RULE_04
         RX_SLEEP_REQUEST:
         begin
            if (rx_is00)
               rx_st_d = RX_SLEEP; // RULE_18
            else if (rx_is01)
               rx_st_d = RX_WAIT; // RULE_15
            else if (rx_is11)
               rx_st_d = RX_STOP; // RULE_15
         end
         RX_SLEEP: if (rx_is10) rx_st_d = RX_SLEEP_EXIT; // RULE_18
         RX_SLEEP_EXIT: if (rx_is11) rx_st_d = RX_STOP; // RULE_18
         RX_WAIT: if (rx_is11) rx_st_d = RX_STOP; // RULE_15
         default:
            rx_st_d = RX_STOP;
      endcase
   end

   // Outputs {term, fast_en, clk_valid, clk, stop, sleep} follow the next state.
   wire rx_nx_term = (rx_st_d == RX_TERMINATION) || (rx_st_d == RX_CLOCK_RECEIVE)
                     || (rx_st_d == RX_END);
   wire rx_nx_fast = (rx_st_d == RX_TERMINATION) || (rx_st_d == RX_CLOCK_RECEIVE);
   wire rx_nx_valid = (rx_st_d == RX_CLOCK_RECEIVE);
   wire rx_nx_sleep = (rx_st_d == RX_SLEEP) && rx_is00;

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rx_st_q <= RX_STOP;
         rx_tmr_q <= TW'(1);
         rx_out_q <= 6'h02;
      end
      else
      begin
         rx_st_q <= rx_st_d;
         rx_out_q <= {rx_nx_term, rx_nx_fast, rx_nx_valid, rx_nx_valid && rx_hs_q,
                      rx_st_d == RX_STOP, rx_nx_sleep}; // RULE_12 RULE_13 RULE_16
         if (rx_st_d != rx_st_q || (rx_edge && rx_st_q == RX_CLOCK_RECEIVE))
            rx_tmr_q <= rx_len(rx_st_d); // RULE_22 RULE_03 RULE_13
         else if (rx_tmr_q != TW'(1))
            rx_tmr_q <= rx_tmr_q - TW'(1);
      end
   end

   assign rx_term_en_o = rx_out_q[5];
   assign rx_fast_en_o = rx_out_q[4];
   assign rx_clk_valid_o = rx_out_q[3];
   assign rx_clk_o = rx_out_q[2];
   assign rx_stop_o = rx_out_q[1];
   assign rx_deep_sleep_o = rx_out_q[0];

endmodule

`default_nettype wire

// file: test/scl_far_lane.sv
`timescale 1ns/100ps
`default_nettype none

module scl_far_lane (
   // Commanded line state and clock run.
   input wire logic [1:0] lp_i,
   input wire logic run_i,
   // Lines toward the block.
   output logic p_o,
   output logic n_o,
   output var logic fast_o
);
   assign p_o = lp_i[1];
   assign n_o = lp_i[0];

   initial fast_o = 1'b0;

   // The clock only toggles in a burst and always halts low.
   always
   begin
      #400;
      if (run_i || fast_o)
         fast_o = ~fast_o;
   end
endmodule

`default_nettype wire

// file: test/scl_clock_lane_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module scl_clock_lane_monitor #(
   parameter int WAKEUP_CYC = 5
) (
   // Clock, reset and requests.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic tx_fast_req_i,
   input wire logic tx_sleep_req_i,
   // Transmit side outputs.
   input wire logic tx_clk_ready_o,
   input wire logic tx_stop_o,
   input wire logic tx_sleep_o,
   input wire logic tx_fast_en_o,
   input wire logic tx_fast_lvl_o,
   input wire logic tx_slow_en_o,
   input wire logic tx_slow_p_o,
   input wire logic tx_slow_n_o,
   // Receive side outputs.
   input wire logic rx_term_en_o,
   input wire logic rx_fast_en_o,
   input wire logic rx_clk_valid_o,
   input wire logic rx_clk_o,
   input wire logic rx_stop_o,
   input wire logic rx_deep_sleep_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   logic [1:0] pn_w;
   logic [15:0] run_q;
   assign pn_w = {tx_slow_p_o, tx_slow_n_o};

   // Counts consecutive cycles of driven LP-10.
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || pn_w != 2'h2 || !tx_slow_en_o)
         run_q <= 16'h0;
      else
         run_q <= run_q + 16'h1;
   end

   AST_HS_REQ: assert property (tx_stop_o && tx_fast_req_i |=> pn_w == 2'h1 ##1 pn_w == 2'h0)
      else $error("Fast request line sequence wrong.");
   AST_SWAP: assert property ($rose(tx_fast_en_o) |-> !tx_slow_en_o && $past(pn_w) == 2'h0 ##0
      (!tx_fast_lvl_o)[*3] ##1 tx_fast_lvl_o) else $error("Driver swap or lead zero wrong.");
   AST_DDR: assert property (tx_fast_en_o && tx_fast_lvl_o |=> tx_fast_en_o && !tx_fast_lvl_o)
      else $error("High phase not followed by low phase.");
   AST_HOLD: assert property (tx_fast_en_o && tx_fast_req_i |=> tx_fast_en_o)
      else $error("Clock stopped while requested.");
   AST_TRAIL: assert property ($fell(tx_fast_en_o) |-> !$past(tx_fast_lvl_o) && $past(tx_fast_lvl_o, 2)
      && tx_slow_en_o && pn_w == 2'h3 ##[1:3] tx_stop_o) else $error("Burst end wrong.");
   AST_READY: assert property ($rose(tx_clk_ready_o) |-> tx_fast_en_o && $past(tx_fast_en_o, 8))
      else $error("Ready before pre interval.");
   AST_SLEEP_IN: assert property (tx_stop_o && !tx_fast_req_i && tx_sleep_req_i |=>
      pn_w == 2'h2 ##1 pn_w == 2'h0 && tx_sleep_o) else $error("Sleep entry wrong.");
   AST_WAKE: assert property (tx_slow_en_o && pn_w == 2'h3 && run_q != 16'h0 |-> run_q == WAKEUP_CYC[15:0])
      else $error("Wake interval length wrong.");
   AST_RX_TERM: assert property ($rose(rx_term_en_o) |-> rx_fast_en_o && !rx_clk_valid_o ##1 rx_clk_valid_o)
      else $error("Settle before clock accept wrong.");
   AST_RX_GATE: assert property (!rx_clk_valid_o && !$past(rx_clk_valid_o) |-> !rx_clk_o)
      else $error("Clock passed while not accepted.");
   AST_RX_MISS: assert property ($fell(rx_clk_valid_o) |-> !rx_fast_en_o)
      else $error("Fast receiver left on after miss.");
   AST_RX_STOP: assert property (rx_stop_o |-> !rx_term_en_o && !rx_fast_en_o && !rx_deep_sleep_o)
      else $error("Stop with termination or flags on.");
endmodule

bind scl_clock_lane scl_clock_lane_monitor #(.WAKEUP_CYC(WAKEUP_CYC)) u_monitor (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_fast_req_i(tx_fast_req_i), .tx_sleep_req_i(tx_sleep_req_i),
   .tx_clk_ready_o(tx_clk_ready_o), .tx_stop_o(tx_stop_o), .tx_sleep_o(tx_sleep_o),
   .tx_fast_en_o(tx_fast_en_o), .tx_fast_lvl_o(tx_fast_lvl_o), .tx_slow_en_o(tx_slow_en_o),
   .tx_slow_p_o(tx_slow_p_o), .tx_slow_n_o(tx_slow_n_o), .rx_term_en_o(rx_term_en_o),
   .rx_fast_en_o(rx_fast_en_o), .rx_clk_valid_o(rx_clk_valid_o), .rx_clk_o(rx_clk_o),
   .rx_stop_o(rx_stop_o), .rx_deep_sleep_o(rx_deep_sleep_o)
);

`default_nettype wire

// file: test/scl_clock_lane_tb.sv
`timescale 1ns/100ps
`default_nettype none

module scl_clock_lane_tb;
   localparam int WAKE = 5;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic tx_fast_req_i = 1'b0;
   logic tx_sleep_req_i = 1'b0;
   logic [1:0] lp = 2'h3;
   logic run = 1'b0;
   wire logic rx_p;
   wire logic rx_n;
   wire logic rx_f;
   logic tx_clk_ready_o, tx_stop_o, tx_sleep_o, tx_fast_en_o, tx_fast_lvl_o, tx_slow_en_o;
   logic tx_slow_p_o, tx_slow_n_o, rx_term_en_o, rx_fast_en_o, rx_clk_valid_o, rx_clk_o;
   logic rx_stop_o, rx_deep_sleep_o;
   int error_cnt = 0;
   int samples_checked = 0;

   always #50 clk_i = ~clk_i;

   scl_clock_lane #(.WAKEUP_CYC(WAKE)) DUT (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_fast_req_i(tx_fast_req_i), .tx_sleep_req_i(tx_sleep_req_i),
      .tx_clk_ready_o(tx_clk_ready_o), .tx_stop_o(tx_stop_o), .tx_sleep_o(tx_sleep_o),
      .tx_fast_en_o(tx_fast_en_o), .tx_fast_lvl_o(tx_fast_lvl_o), .tx_slow_en_o(tx_slow_en_o),
      .tx_slow_p_o(tx_slow_p_o), .tx_slow_n_o(tx_slow_n_o), .rx_slow_p_i(rx_p), .rx_slow_n_i(rx_n),
      .rx_fast_lvl_i(rx_f), .rx_term_en_o(rx_term_en_o), .rx_fast_en_o(rx_fast_en_o),
      .rx_clk_valid_o(rx_clk_valid_o), .rx_clk_o(rx_clk_o), .rx_stop_o(rx_stop_o),
      .rx_deep_sleep_o(rx_deep_sleep_o)
   );

   scl_far_lane FAR (.lp_i(lp), .run_i(run), .p_o(rx_p), .n_o(rx_n), .fast_o(rx_f));

   // Code is {slow_en, fast_en, line pair}; LP-11 is b, LP-01 is 9, HS-0 is 4, HS-1 is 6.
   function automatic logic [3:0] pins();
      return {tx_slow_en_o, tx_fast_en_o, tx_fast_en_o ? {tx_fast_lvl_o, 1'b0} : {tx_slow_p_o, tx_slow_n_o}};
   endfunction

   task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task t_reset;
      cyc(4);
      chk("tx pins", 4'hb, pins());
      chk("flags", 4'hc, {tx_stop_o, rx_stop_o, rx_term_en_o | rx_fast_en_o, tx_sleep_o | rx_deep_sleep_o});
   endtask

   task automatic t_tx_burst;
      logic [3:0] seq [8] = '{4'h9, 4'h8, 4'h4, 4'h4, 4'h4, 4'h6, 4'h4, 4'h6};
      int n;
      int hi;
      hi = 2;
      tx_fast_req_i = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         cyc(1);
         chk("burst pins", seq[i], pins());
      end
      for (n = 0; n < 40 && tx_clk_ready_o !== 1'b1; n++)
      begin
         cyc(1);
         hi += (pins() == 4'h6);
      end
      chk("pre phases", 4'h3, {2'h0, hi >= 4, tx_clk_ready_o});
      tx_fast_req_i = 1'b0;
      for (n = 0; n < 200 && tx_fast_en_o === 1'b1; n++)
         cyc(1);
      chk("post length", 4'h1, {3'h0, n >= 53});
      chk("exit pins", 4'hb, pins());
      cyc(2);
      chk("tx stop", 4'h1, {3'h0, tx_stop_o});
   endtask

   task automatic t_tx_sleep;
      int n;
      tx_sleep_req_i = 1'b1;
      cyc(1);
      chk("sleep req pins", 4'ha, pins());
      cyc(1);
      chk("sleep pins", 4'h9, {pins() == 4'h8, 2'h0, tx_sleep_o});
      tx_fast_req_i = 1'b1;
      cyc(3);
      chk("sleep holds", 4'h8, pins());
      tx_fast_req_i = 1'b0;
      tx_sleep_req_i = 1'b0;
      n = 0;
      cyc(1);
      while (n < 20 && pins() == 4'ha)
      begin
         n++;
         cyc(1);
      end
      chk("wake length", WAKE[3:0], n[3:0]);
      chk("wake pins", 4'hb, pins());
      cyc(2);
      chk("tx stop", 4'h1, {3'h0, tx_stop_o});
   endtask

   task automatic t_rx_burst;
      int n;
      lp = 2'h1;
      cyc(8);
      chk("rx stop", 4'h0, {3'h0, rx_stop_o});
      lp = 2'h0;
      for (n = 0; n < 12 && rx_term_en_o !== 1'b1; n++)
         cyc(1);
      chk("term and fast", 4'h3, {2'h0, rx_term_en_o, rx_fast_en_o});
      run = 1'b1;
      for (n = 0; n < 12 && rx_clk_valid_o !== 1'b1; n++)
         cyc(1);
      chk("clock valid", 4'h1, {3'h0, rx_clk_valid_o});
      cyc(16);
      run = 1'b0;
      cyc(20);
      chk("after miss", 4'h2, {1'b0, rx_fast_en_o, rx_term_en_o, rx_clk_o});
      lp = 2'h3;
      cyc(8);
      chk("back to stop", 4'h1, {2'h0, rx_term_en_o, rx_stop_o});
   endtask

   task t_rx_sleep;
      lp = 2'h2;
      cyc(8);
      lp = 2'h0;
      cyc(8);
      chk("deep sleep", 4'h1, {3'h0, rx_deep_sleep_o});
      lp = 2'h2;
      cyc(8);
      chk("sleep exit", 4'h0, {2'h0, rx_deep_sleep_o, rx_stop_o});
      lp = 2'h3;
      cyc(8);
      chk("stop", 4'h1, {3'h0, rx_stop_o});
   endtask

   task automatic t_rx_abort;
      logic [1:0] bad [2] = '{2'h1, 2'h3};
      for (int i = 0; i < 2; i++)
      begin
         lp = 2'h2;
         cyc(8);
         lp = bad[i];
         cyc(8);
         chk("abort", {1'b0, bad[i] == 2'h3, 2'h0}, {1'b0, rx_stop_o, rx_term_en_o, rx_deep_sleep_o});
         lp = 2'h3;
         cyc(8);
         chk("stop", 4'h1, {3'h0, rx_stop_o});
      end
   endtask

   initial
   begin
      cyc(10);
      sys_rst_i = 1'b0;
      t_reset;
      t_tx_burst;
      t_tx_sleep;
      t_rx_burst;
      t_rx_sleep;
      t_rx_abort;
      tx_fast_req_i = 1'b1;
      cyc(8);
      sys_rst_i = 1'b1;
      cyc(3);
      sys_rst_i = 1'b0;
      tx_fast_req_i = 1'b0;
      t_reset;
      tally_and_finish;
   end

   initial
   begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      $display("[FAIL] watchdog expected done seen timeout");
      tally_and_finish;
   end
endmodule

`default_nettype wire
